// File: inc/tps_pkg.sv
`default_nettype none
package tps_pkg;
   // ====================================
   // Object indices and subindices
   localparam logic [15:0] IDX_TORQUE_SET = 16'h6071;
   localparam logic [15:0] IDX_TORQUE_MAX = 16'h6072;
   localparam logic [15:0] IDX_TORQUE_DEM = 16'h6074;
   localparam logic [15:0] IDX_RATED_CUR = 16'h6075;
   localparam logic [15:0] IDX_TORQUE_ACT = 16'h6077;
   localparam logic [15:0] IDX_POS_SET = 16'h607A;
   localparam logic [15:0] IDX_POS_RANGE = 16'h607B;
   localparam logic [15:0] IDX_HOME_OFS = 16'h607C;
   localparam logic [15:0] IDX_SOFT_LIM = 16'h607D;
   localparam logic [15:0] IDX_RATED_REF = 16'h203B;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [7:0] SUB_SECOND = 8'h02;
   localparam logic [31:0] ARRAY_COUNT = 32'h0000_0002;
   // ====================================
   // Reset values
   localparam logic [15:0] RST_TORQUE = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_POS_SET = 32'h0000_0FA0;
   // ====================================
   // Scaling and status layout
   localparam logic [41:0] PERMILLE_FULL = 42'h000_0000_03E8;
   localparam logic [15:0] TORQUE_SAT = 16'hFFFF;
   localparam int STATUS_VEL_BIT = 10;
   // ====================================
   // Timing
   localparam int MS_TIME_NS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_STEPS = 42;
endpackage : tps_pkg
`default_nettype wire

// File: rtl/tps_window_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tps_window_timer #(
   parameter int MS_CYCLES = tps_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [31:0] speedActual,
   input wire logic signed [31:0] speedDemand,
   input wire logic [15:0] window,
   input wire logic [15:0] windowTime,
   output logic reached
);
   if (MS_CYCLES < 1) $error("MS_CYCLES must be at least 1");

   // ====================================
   // Millisecond enable
   logic [31:0] msCnt;
   logic msTick;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         msCnt <= 32'h0000_0000;
         msTick <= 1'b0;
      end else if (msCnt == 32'(MS_CYCLES - 1)) begin
         msCnt <= 32'h0000_0000;
         msTick <= 1'b1;
      end else begin
         msCnt <= msCnt + 32'h0000_0001;
         msTick <= 1'b0;
      end
   end

   // ====================================
   // Window check and dwell time
   logic signed [32:0] diff;
   logic [32:0] diffMag;
   logic inWin;
   logic [16:0] elapsed;
   assign diff = 33'(speedActual) - 33'(speedDemand);
   assign diffMag = diff[32] ? 33'(-diff) : 33'(diff);
   assign inWin = diffMag < 33'(window);

   // Elapsed saturates, so a long dwell never wraps back below the time
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         elapsed <= 17'h0_0000;
         reached <= 1'b0;
      end else begin
         if (!inWin) begin
            elapsed <= 17'h0_0000;
         end else if (msTick && elapsed != 17'h1_FFFF) begin
            elapsed <= elapsed + 17'h0_0001;
         end
         reached <= inWin && (elapsed > 17'(windowTime));
      end
   end

   a_vel_drop: assert property (@(posedge clk) disable iff (!rst_n) !inWin |=> !reached)
      else $error("velocity reached while outside window");
   a_vel_dwell: assert property (@(posedge clk) disable iff (!rst_n)
      reached |-> $past(elapsed) > 17'($past(windowTime)))
      else $error("velocity reached before dwell time");
   c_vel_reached: cover property (@(posedge clk) disable iff (!rst_n) $rose(reached));
endmodule : tps_window_timer
`default_nettype wire

// File: rtl/tps_setpoint_limits.sv
// Contract
// - Status bit 10 set once speed stays inside velocity window longer than window time.
// - Target torque is signed 16-bit, tenths of a percent of rated torque.
// - Rated torque reference comes from rated current at subindex 01 of 203B.
// - Applied torque never exceeds peak torque, proportional to peak current.
// - Unsigned 16-bit maximum torque bounds torque in torque modes.
// - Ramp generator torque demand is readable, read-only, signed 16-bit.
// - Motor rated current, unsigned 32-bit mA, mirrors the scaling rated current.
// - Measured torque is readable, read-only, signed 16-bit.
// - Signed 32-bit target position, preset 00000FA0 hex.
// - Position range min/max at subindices 1 and 2, read-only count 02; overflow beyond.
// - Target and demand positions kept inside software position limits.
// - Software limit comparison ignores the home offset.
// - Signed 32-bit home offset between own zero and machine reference.
`timescale 1ns/1ps
`default_nettype none
module tps_setpoint_limits #(
   parameter int MS_CYCLES = tps_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic objReq,
   input wire logic objWrite,
   input wire logic [15:0] objIndex,
   input wire logic [7:0] objSub,
   input wire logic [31:0] objWdata,
   output logic objAck,
   output logic objErr,
   output logic [31:0] objRdata,
   input wire logic signed [15:0] torqueDemandIn,
   input wire logic signed [15:0] torqueActualIn,
   input wire logic [31:0] peakCurrentMa,
   output logic signed [15:0] torqueLimited,
   input wire logic signed [31:0] positionDemandIn,
   output logic signed [31:0] positionDemandOut,
   output logic signed [31:0] positionTargetOut,
   input wire logic signed [31:0] velocityActual,
   input wire logic signed [31:0] velocityDemand,
   input wire logic [15:0] velWindow,
   input wire logic [15:0] velWindowTime,
   output logic [15:0] statusWord
);
   if (MS_CYCLES < 1) $error("MS_CYCLES must be at least 1");

   // ====================================
   // Object storage
   logic signed [15:0] torqueSetpoint;
   logic [15:0] torqueCeiling;
   logic signed [15:0] torqueDemand;
   logic signed [15:0] torqueMeasured;
   logic [31:0] ratedCurrentMa;
   logic signed [31:0] positionSetpoint;
   logic signed [31:0] rangeMin;
   logic signed [31:0] rangeMax;
   logic signed [31:0] zeroOffset;
   logic signed [31:0] softMin;
   logic signed [31:0] softMax;

   logic hit;
   logic readOnly;
   logic [31:0] readVal;
   always_comb begin
      hit = 1'b1;
      readOnly = 1'b0;
      readVal = tps_pkg::RST_WORD;
      unique case (objIndex)
         tps_pkg::IDX_TORQUE_SET: readVal = 32'({16'h0000, torqueSetpoint});
         tps_pkg::IDX_TORQUE_MAX: readVal = 32'({16'h0000, torqueCeiling});
         tps_pkg::IDX_TORQUE_DEM: begin
            readVal = 32'({16'h0000, torqueDemand});
            readOnly = 1'b1;
         end
         tps_pkg::IDX_TORQUE_ACT: begin
            readVal = 32'({16'h0000, torqueMeasured});
            readOnly = 1'b1;
         end
         tps_pkg::IDX_RATED_CUR: readVal = ratedCurrentMa;
         tps_pkg::IDX_RATED_REF: begin
            readVal = ratedCurrentMa;
            hit = (objSub == tps_pkg::SUB_FIRST);
         end
         tps_pkg::IDX_POS_SET: readVal = positionSetpoint;
         tps_pkg::IDX_HOME_OFS: readVal = zeroOffset;
         tps_pkg::IDX_POS_RANGE, tps_pkg::IDX_SOFT_LIM: begin
            readOnly = (objSub == tps_pkg::SUB_COUNT);
            hit = (objSub <= tps_pkg::SUB_SECOND);
            if (objSub == tps_pkg::SUB_COUNT) begin
               readVal = tps_pkg::ARRAY_COUNT;
            end else if (objIndex == tps_pkg::IDX_POS_RANGE) begin
               readVal = (objSub == tps_pkg::SUB_FIRST) ? rangeMin : rangeMax;
            end else begin
               readVal = (objSub == tps_pkg::SUB_FIRST) ? softMin : softMax;
            end
         end
         default: hit = 1'b0;
      endcase
   end

   logic wrOk;
   assign wrOk = objReq && objWrite && hit && !readOnly;

   // Both rated current objects share one store so scaling cannot diverge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         torqueSetpoint <= tps_pkg::RST_TORQUE;
         torqueCeiling <= tps_pkg::RST_TORQUE;
         ratedCurrentMa <= tps_pkg::RST_WORD;
         positionSetpoint <= tps_pkg::RST_POS_SET;
         rangeMin <= tps_pkg::RST_WORD;
         rangeMax <= tps_pkg::RST_WORD;
         zeroOffset <= tps_pkg::RST_WORD;
         softMin <= tps_pkg::RST_WORD;
         softMax <= tps_pkg::RST_WORD;
      end else if (wrOk) begin
         unique case (objIndex)
            tps_pkg::IDX_TORQUE_SET: torqueSetpoint <= objWdata[15:0];
            tps_pkg::IDX_TORQUE_MAX: torqueCeiling <= objWdata[15:0];
            tps_pkg::IDX_RATED_CUR, tps_pkg::IDX_RATED_REF: ratedCurrentMa <= objWdata;
            tps_pkg::IDX_POS_SET: positionSetpoint <= objWdata;
            tps_pkg::IDX_HOME_OFS: zeroOffset <= objWdata;
            tps_pkg::IDX_POS_RANGE: begin
               if (objSub == tps_pkg::SUB_FIRST) rangeMin <= objWdata;
               else rangeMax <= objWdata;
            end
            tps_pkg::IDX_SOFT_LIM: begin
               if (objSub == tps_pkg::SUB_FIRST) softMin <= objWdata;
               else softMax <= objWdata;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         objAck <= 1'b0;
         objErr <= 1'b0;
         objRdata <= tps_pkg::RST_WORD;
      end else begin
         objAck <= objReq;
         objErr <= objReq && (!hit || (objWrite && readOnly));
         objRdata <= (objReq && !objWrite && hit) ? readVal : tps_pkg::RST_WORD;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         torqueDemand <= tps_pkg::RST_TORQUE;
         torqueMeasured <= tps_pkg::RST_TORQUE;
      end else begin
         torqueDemand <= torqueDemandIn;
         torqueMeasured <= torqueActualIn;
      end
   end

   // ====================================
   // Peak torque in permille: peak current * 1000 / rated current
   // Serial divider trades 42 cycles of latency for no wide divider
   typedef enum logic {DIV_LOAD, DIV_RUN} tps_div_e;
   tps_div_e divState;
   logic [41:0] divNum;
   logic [31:0] divDen;
   logic [32:0] divRem;
   logic [5:0] divCnt;
   logic [15:0] peakLimit;
   logic [32:0] divShift;
   logic divBit;
   logic [41:0] divQuot;
   assign divShift = {divRem[31:0], divNum[41]};
   assign divBit = divShift >= {1'b0, divDen};
   assign divQuot = {divNum[40:0], divBit};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divState <= DIV_LOAD;
         divNum <= 42'h000_0000_0000;
         divDen <= tps_pkg::RST_WORD;
         divRem <= 33'h0_0000_0000;
         divCnt <= 6'h00;
         peakLimit <= tps_pkg::RST_TORQUE;
      end else begin
         unique case (divState)
            DIV_LOAD: begin
               divNum <= 42'(peakCurrentMa) * tps_pkg::PERMILLE_FULL;
               divDen <= ratedCurrentMa;
               divRem <= 33'h0_0000_0000;
               divCnt <= 6'(tps_pkg::DIV_STEPS);
               divState <= DIV_RUN;
            end
            DIV_RUN: begin
               divRem <= divBit ? divShift - {1'b0, divDen} : divShift;
               divNum <= divQuot;
               divCnt <= divCnt - 6'h01;
               if (divCnt == 6'h01) begin
                  // No rated current means no reference: hold torque at zero
                  if (divDen == tps_pkg::RST_WORD) peakLimit <= tps_pkg::RST_TORQUE;
                  else if (divQuot > 42'(tps_pkg::TORQUE_SAT)) peakLimit <= tps_pkg::TORQUE_SAT;
                  else peakLimit <= divQuot[15:0];
                  divState <= DIV_LOAD;
               end
            end
         endcase
      end
   end

   // ====================================
   // Torque saturation
   logic [15:0] torqueBound;
   logic signed [16:0] boundPos;
   logic signed [16:0] torqueWide;
   assign torqueBound = (torqueCeiling < peakLimit) ? torqueCeiling : peakLimit;
   assign boundPos = 17'({1'b0, torqueBound});
   assign torqueWide = 17'(torqueSetpoint);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         torqueLimited <= tps_pkg::RST_TORQUE;
      end else if (torqueWide > boundPos) begin
         torqueLimited <= boundPos[15:0];
      end else if (torqueWide < -boundPos) begin
         torqueLimited <= 16'(-boundPos);
      end else begin
         torqueLimited <= torqueSetpoint;
      end
   end

   // ====================================
   // Position wrap and software limits
   // Limits are inactive while min is not below max; home offset is never applied
   function automatic logic signed [31:0] tps_clamp(input logic signed [31:0] p,
         input logic signed [31:0] lo, input logic signed [31:0] hi);
      if (lo >= hi) return p;
      if (p < lo) return lo;
      if (p > hi) return hi;
      return p;
   endfunction : tps_clamp

   // One fold only: a demand more than one range span outside stays partly out
   function automatic logic signed [31:0] tps_wrap(input logic signed [31:0] p,
         input logic signed [31:0] lo, input logic signed [31:0] hi);
      logic signed [33:0] w;
      w = 34'(p);
      if (lo >= hi) return p;
      if (p > hi) w = 34'(lo) + 34'(p) - 34'(hi) - 34'sd1;
      else if (p < lo) w = 34'(hi) - 34'(lo) + 34'(p) + 34'sd1;
      return w[31:0];
   endfunction : tps_wrap

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         positionTargetOut <= tps_pkg::RST_POS_SET;
         positionDemandOut <= tps_pkg::RST_WORD;
      end else begin
         positionTargetOut <= tps_clamp(positionSetpoint, softMin, softMax);
         positionDemandOut <= tps_clamp(tps_wrap(positionDemandIn, rangeMin, rangeMax),
            softMin, softMax);
      end
   end

   // ====================================
   // Velocity reached status
   logic velReached;
   tps_window_timer #(.MS_CYCLES(MS_CYCLES)) uTimer (
      .clk(clk),
      .rst_n(rst_n),
      .speedActual(velocityActual),
      .speedDemand(velocityDemand),
      .window(velWindow),
      .windowTime(velWindowTime),
      .reached(velReached)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) statusWord <= tps_pkg::RST_TORQUE;
      else statusWord <= 16'(velReached) << tps_pkg::STATUS_VEL_BIT;
   end

   // ====================================
   // Checks
   logic signed [16:0] limWide;
   assign limWide = 17'(torqueLimited);

   a_torque_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> limWide <= $signed({1'b0, $past(torqueCeiling)})
      && limWide >= -$signed({1'b0, $past(torqueCeiling)}))
      else $error("torque above maximum torque");
   a_torque_peak: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> limWide <= $signed({1'b0, $past(peakLimit)})
      && limWide >= -$signed({1'b0, $past(peakLimit)}))
      else $error("torque above peak torque");
   a_torque_pass: assert property (@(posedge clk) disable iff (!rst_n)
      (torqueWide <= boundPos && torqueWide >= -boundPos) |=> torqueLimited == $past(torqueSetpoint))
      else $error("torque inside bound was altered");
   a_demand_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      (objReq && !objWrite && objIndex == tps_pkg::IDX_TORQUE_DEM) |=> objRdata[15:0] == $past(torqueDemand))
      else $error("torque demand read mismatch");
   a_rated_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      (objReq && objWrite && objIndex == tps_pkg::IDX_RATED_REF && objSub == tps_pkg::SUB_FIRST)
      ##1 !objReq ##1 (objReq && !objWrite && objIndex == tps_pkg::IDX_RATED_CUR) |=> objRdata == $past(objWdata, 3))
      else $error("rated current objects disagree");
   a_count_ro: assert property (@(posedge clk) disable iff (!rst_n)
      (objReq && objWrite && objIndex == tps_pkg::IDX_POS_RANGE && objSub == tps_pkg::SUB_COUNT)
      |=> objAck && objErr)
      else $error("write to count accepted");
   a_target_limits: assert property (@(posedge clk) disable iff (!rst_n)
      (softMin < softMax) ##1 $stable(softMin) && $stable(softMax) |->
      positionTargetOut >= softMin && positionTargetOut <= softMax)
      else $error("target position outside software limits");
   a_wrap_fold: assert property (@(posedge clk) disable iff (!rst_n)
      (rangeMin < rangeMax && softMin >= softMax && positionDemandIn == rangeMax + 32'sd1
      && rangeMax != 32'sh7FFF_FFFF) |=> positionDemandOut == $past(rangeMin))
      else $error("range overflow did not wrap to minimum");
   a_status_bit: assert property (@(posedge clk) disable iff (!rst_n)
      velReached |=> statusWord[tps_pkg::STATUS_VEL_BIT] ##0 statusWord[9:0] == 10'h000)
      else $error("velocity reached not reported");

   c_torque_clip: cover property (@(posedge clk) disable iff (!rst_n) torqueWide > boundPos && boundPos != 17'sd0);
   c_demand_wrap: cover property (@(posedge clk) disable iff (!rst_n)
      rangeMin < rangeMax && positionDemandIn < rangeMin);
   c_bad_index: cover property (@(posedge clk) disable iff (!rst_n) objReq && !hit);
endmodule : tps_setpoint_limits
`default_nettype wire

// File: test/tps_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Fieldbus master model on the object port
module tps_master (
   input wire logic clk,
   output logic objReq,
   output logic objWrite,
   output logic [15:0] objIndex,
   output logic [7:0] objSub,
   output logic [31:0] objWdata,
   input wire logic objAck,
   input wire logic objErr,
   input wire logic [31:0] objRdata
);
   initial begin
      objReq = 1'b0;
      objWrite = 1'b0;
      objIndex = 16'h0000;
      objSub = 8'h00;
      objWdata = 32'h0000_0000;
   end
   // Idle write data and index are inverted so a stale value can never pass as valid
   task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sb,
      input logic [31:0] wd, output logic ack, output logic err, output logic [31:0] rd);
      @(posedge clk);
      objReq <= 1'b1;
      objWrite <= w;
      objIndex <= idx;
      objSub <= sb;
      objWdata <= wd;
      @(posedge clk);
      objReq <= 1'b0;
      objWdata <= ~wd;
      objIndex <= ~idx;
      #1;
      ack = objAck;
      err = objErr;
      rd = objRdata;
   endtask : access
endmodule : tps_master
`default_nettype wire

// File: test/tps_setpoint_limits_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tps_setpoint_limits_tb;
   logic clk, rst_n, objReq, objWrite, objAck, objErr;
   logic [15:0] objIndex, velWindow, velWindowTime, statusWord;
   logic [7:0] objSub;
   logic [31:0] objWdata, objRdata, peakCurrentMa;
   logic signed [15:0] torqueDemandIn, torqueActualIn, torqueLimited;
   logic signed [31:0] positionDemandIn, positionDemandOut, positionTargetOut;
   logic signed [31:0] velocityActual, velocityDemand;
   int n_mismatch = 0;
   int total_checks = 0;
   int tSet, tMax, rated, peak, sMin, sMax, rMin, rMax, p;
   // ==========================================
   // Clock, reset, instances
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      peakCurrentMa = '0;
      torqueDemandIn = '0;
      torqueActualIn = '0;
      positionDemandIn = '0;
      velocityActual = '0;
      velocityDemand = '0;
      velWindow = '0;
      velWindowTime = '0;
   end
   tps_master m (.clk(clk), .objReq(objReq), .objWrite(objWrite), .objIndex(objIndex),
      .objSub(objSub), .objWdata(objWdata), .objAck(objAck), .objErr(objErr), .objRdata(objRdata));
   tps_setpoint_limits #(.MS_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n), .objReq(objReq),
      .objWrite(objWrite), .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata),
      .objAck(objAck), .objErr(objErr), .objRdata(objRdata), .torqueDemandIn(torqueDemandIn),
      .torqueActualIn(torqueActualIn), .peakCurrentMa(peakCurrentMa), .torqueLimited(torqueLimited),
      .positionDemandIn(positionDemandIn), .positionDemandOut(positionDemandOut),
      .positionTargetOut(positionTargetOut), .velocityActual(velocityActual),
      .velocityDemand(velocityDemand), .velWindow(velWindow), .velWindowTime(velWindowTime),
      .statusWord(statusWord));
   // ==========================================
   // Reference model and checks
   function automatic logic [15:0] expT();
      int pl, b, t;
      pl = (rated == 0) ? 0 : peak * 1000 / rated;
      if (pl > 65535) pl = 65535;
      b = (tMax < pl) ? tMax : pl;
      t = tSet;
      if (t > b) t = b;
      if (t < -b) t = -b;
      return t[15:0];
   endfunction : expT
   function automatic logic [31:0] expP(input int q, input logic wrap);
      if (wrap && rMin < rMax && q > rMax) q = rMin + (q - rMax - 1);
      else if (wrap && rMin < rMax && q < rMin) q = rMax - (rMin - q - 1);
      if (sMin < sMax && q > sMax) q = sMax;
      if (sMin < sMax && q < sMin) q = sMin;
      return q[31:0];
   endfunction : expP
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk
   task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic e, input logic [31:0] x);
      logic a, er;
      logic [31:0] r;
      m.access(w, i, s, d, a, er, r);
      chk({30'h0, a, er}, {30'h0, 1'b1, e});
      chk(r, x);
   endtask : acc
   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   // ==========================================
   // Scenarios
   initial begin
      automatic logic [15:0] badI [7] = '{16'h6074, 16'h6077, 16'h607B, 16'h607D, 16'h1234, 16'h607B, 16'h203B};
      automatic logic [7:0] badS [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02};
      void'($urandom(32'h9717));
      rated = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(positionTargetOut, 32'h0000_0FA0);
      chk({16'h0000, torqueLimited}, 32'h0000_0000);
      acc(0, 16'h6071, 0, 0, 0, 0);
      acc(0, 16'h6072, 0, 0, 0, 0);
      acc(0, 16'h6075, 0, 0, 0, 0);
      acc(0, 16'h607A, 0, 0, 0, 32'h0000_0FA0);
      acc(0, 16'h607B, 0, 0, 0, 32'h0000_0002);
      acc(0, 16'h607B, 2, 0, 0, 0);
      acc(0, 16'h607C, 0, 0, 0, 0);
      acc(0, 16'h607D, 0, 0, 0, 32'h0000_0002);
      @(posedge clk);
      torqueDemandIn <= 16'(-int'($urandom % 900));
      torqueActualIn <= 16'($urandom);
      @(posedge clk);
      acc(0, 16'h6074, 0, 0, 0, {16'h0000, torqueDemandIn});
      acc(0, 16'h6077, 0, 0, 0, {16'h0000, torqueActualIn});
      for (int i = 0; i < 7; i++) acc(1, badI[i], badS[i], 32'h0000_1234, 1, 0);
      acc(0, 16'h607B, 0, 0, 0, 32'h0000_0002);
      p = $urandom;
      acc(1, 16'h607C, 0, p, 0, 0);
      acc(0, 16'h607C, 0, 0, 0, p);
      // Rated current through both objects, then the clamp over random bounds
      for (int i = 0; i < 5; i++) begin
         rated = 500 + $urandom % 3000;
         peak = (i == 4) ? 2000000 : $urandom % 6000;
         tMax = (i == 3) ? 0 : $urandom % 3000;
         tSet = int'($urandom % 8000) - 4000;
         acc(1, (i[0] ? 16'h203B : 16'h6075), 1, rated, 0, 0);
         acc(0, (i[0] ? 16'h6075 : 16'h203B), 1, 0, 0, rated);
         acc(1, 16'h6072, 0, tMax, 0, 0);
         acc(1, 16'h6071, 0, tSet, 0, 0);
         acc(0, 16'h6071, 0, 0, 0, {16'h0000, tSet[15:0]});
         @(posedge clk);
         peakCurrentMa <= peak;
         // Divider may be mid-run on the old currents: two full passes
         repeat (100) @(posedge clk);
         #1;
         chk({16'h0000, torqueLimited}, {16'h0000, expT()});
      end
      // Soft limits, home offset left in place
      sMin = -500;
      sMax = 800;
      rMin = -1000;
      rMax = 1000;
      acc(1, 16'h607B, 1, rMin, 0, 0);
      acc(1, 16'h607B, 2, rMax, 0, 0);
      acc(0, 16'h607B, 1, 0, 0, rMin);
      // Plain wrap while soft limits are still off
      @(posedge clk);
      positionDemandIn <= rMax + 1;
      repeat (3) @(posedge clk);
      #1;
      chk(positionDemandOut, rMin);
      acc(1, 16'h607D, 1, sMin, 0, 0);
      acc(1, 16'h607D, 2, sMax, 0, 0);
      for (int i = 0; i < 8; i++) begin
         p = (i == 0) ? 1001 : (i == 1) ? -1001 : (i == 2) ? 800 : int'($urandom % 5000) - 2500;
         acc(1, 16'h607A, 0, p, 0, 0);
         @(posedge clk);
         positionDemandIn <= p;
         repeat (3) @(posedge clk);
         #1;
         chk(positionTargetOut, expP(p, 0));
         chk(positionDemandOut, expP(p, 1));
      end
      // Velocity window: on the edge, inside, then out again
      @(posedge clk);
      velWindow <= 16'h0005;
      velWindowTime <= 16'h0003;
      velocityDemand <= 1000;
      velocityActual <= 1005;
      repeat (60) @(posedge clk);
      #1;
      chk({16'h0000, statusWord}, 32'h0000_0000);
      @(posedge clk);
      velocityActual <= 996;
      repeat (15) @(posedge clk);
      #1;
      chk({16'h0000, statusWord}, 32'h0000_0000);
      repeat (60) @(posedge clk);
      #1;
      chk({16'h0000, statusWord}, 32'h0000_0400);
      @(posedge clk);
      velocityActual <= 1010;
      repeat (5) @(posedge clk);
      #1;
      chk({16'h0000, statusWord}, 32'h0000_0000);
      results();
   end
endmodule : tps_setpoint_limits_tb
`default_nettype wire
